/* src/breaker_command_control.sv */
// Breaker open/close command supervision with interlock, synchro and timing checks
// Contract
// - Accept local and remote commands, check, then drive
// - Present filtered breaker position to local and remote
// - Separate enables for local and remote acceptance
// - Open needs open permit, close needs close permit
// - User block condition suspends all command operation
// - Model select: direct normal, enhanced, SBO; reset normal
// - Forced check overrides request to skip checks
// - Enhanced models: no status change reports invalid position
// - Command pulses last the pulse time setting
// - Confirmed switching ends pulse early, not before 100ms
// - Invalid status past intermediate limit reports intermediate
// - Close waits for sync ok; on wait expiry starts synchro switch
// - Synchro switch wait expiry resets without command
// - Zero synchro switch limit never asserts start output
// - SBO selection without operate times out, nothing done
// - Every breaker operation gives a 150ms indication pulse
// - Uncommanded unexplained status change flags unintended operation
// - Process block input refuses all breaker operation
`timescale 1ns/1ps

module breaker_command_control
   import breaker_ctrl_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  config_load,
   input  wire logic [1:0]            control_model_select,
   input  wire logic                  forced_check,
   input  wire logic [15:0]           oper_time_ms,
   input  wire logic [15:0]           pulse_time_ms,
   input  wire logic [15:0]           interm_time_ms,
   input  wire logic [15:0]           sync_wait_timeout,
   input  wire logic [15:0]           sync_switch_timeout,
   input  wire logic [15:0]           select_timeout,
   input  wire logic                  local_enable,
   input  wire logic                  remote_enable,
   input  wire logic                  local_open_req,
   input  wire logic                  local_close_req,
   input  wire logic                  remote_select_req,
   input  wire logic                  remote_operate_req,
   input  wire logic                  remote_dir_close,
   input  wire logic                  remote_skip_check,
   input  wire logic                  open_permit,
   input  wire logic                  close_permit,
   input  wire logic                  user_block_in,
   input  wire logic                  process_block_in,
   input  wire logic                  sync_ok_in,
   input  wire logic                  sync_switch_impulse_in,
   input  wire logic                  open_status_in,
   input  wire logic                  closed_status_in,
   input  wire logic                  external_command_seen,
   output logic                       open_command_out,
   output logic                       close_command_out,
   output logic                       sync_switch_start,
   output logic                       operation_out,
   output logic                       operation_event_out,
   output logic [OP_COUNT_W-1:0]      operation_count,
   output logic                       unintended_operation_out,
   output logic                       opened_out,
   output logic                       closed_out,
   output logic                       intermediate_out,
   output logic                       invalid_position_out,
   output logic                       select_active_out,
   output logic                       cmd_refused_out
);

   // Registers
   cmd_state_e            state_reg, state_next;
   logic [15:0]           presc_reg;
   logic [15:0]           timer_ms_reg;
   logic [15:0]           interm_ms_reg;
   logic [15:0]           sup_ms_reg;
   logic [15:0]           oper_ms_reg;
   logic                  sup_active_reg;
   logic                  dir_close_reg;
   logic                  known_reg;
   logic [1:0]            model_reg;
   logic                  forced_reg;
   logic                  open_cmd_reg, close_cmd_reg, sw_start_reg, oper_reg, event_reg;
   logic [OP_COUNT_W-1:0] count_reg;
   logic                  unint_reg, opened_reg, closed_reg, interm_reg, invalid_reg;
   logic                  refused_reg, sel_reg;
   // Millisecond timebase
   wire ms_tick = (presc_reg == 16'(CYCLES_PER_MS - 1));
   // Status decoding: valid only with exactly one contact active
   wire status_valid = open_status_in ^ closed_status_in;
   wire pos_change   = status_valid && known_reg && (closed_status_in != closed_reg);
   // Command sources and the checks they pass
   wire blocked      = user_block_in | process_block_in;
   wire enhanced     = (model_reg == MODEL_DIRECT_ENH) || (model_reg == MODEL_SBO_ENH);
   wire sbo_mode     = (model_reg == MODEL_SBO_ENH);
   wire local_take   = local_enable & (local_open_req | local_close_req);
   wire remote_op    = remote_enable & remote_operate_req;
   wire remote_sel   = remote_enable & remote_select_req & sbo_mode;
   wire sel_match    = (state_reg == ST_SELECTED) && (remote_dir_close == dir_close_reg);
   wire remote_take  = remote_op && (!sbo_mode || sel_match);
   wire req_close    = local_take ? local_close_req : remote_dir_close;
   wire chk          = local_take | forced_reg | ~remote_skip_check;
   wire permit_ok    = !chk || (req_close ? close_permit : open_permit);
   wire cmd_ready    = (state_reg == ST_IDLE) || (state_reg == ST_SELECTED);
   wire take_any     = cmd_ready && !blocked && (local_take || remote_take);
   wire go_cmd       = take_any && permit_ok;
   wire go_open      = go_cmd && !req_close;
   wire refuse       = (cmd_ready && (local_take || remote_op) && !go_cmd) ||
                       (blocked && (local_take || remote_op || remote_sel));
   wire target_hit   = status_valid && (dir_close_reg ? closed_status_in : open_status_in);
   wire timer_at     = ms_tick;
   wire sync_need    = go_cmd && req_close && chk && !sync_ok_in;
   wire pulse_done   = ms_tick && (timer_ms_reg + 16'h0001 >= pulse_time_ms);
   wire early_done   = target_hit && (timer_ms_reg >= MIN_PULSE_MS);
   wire cmd_window   = (state_reg != ST_IDLE) || sup_active_reg;
   // Next state of the command sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (remote_sel && !blocked) state_next = ST_SELECTED;
            else if (go_cmd) state_next = sync_need ? ST_SYNC_WAIT : ST_PULSE;
         end
         ST_SELECTED: begin
            if (blocked) state_next = ST_IDLE;
            else if (go_cmd) state_next = sync_need ? ST_SYNC_WAIT : ST_PULSE;
            else if (remote_op) state_next = ST_IDLE;          // Mismatched operate drops it
            else if (timer_at && timer_ms_reg + 16'h0001 >= select_timeout)
               state_next = ST_IDLE;
         end
         ST_SYNC_WAIT: begin
            if (blocked) state_next = ST_IDLE;
            else if (sync_ok_in) state_next = ST_PULSE;
            else if (timer_at && timer_ms_reg + 16'h0001 >= sync_wait_timeout)
               state_next = (sync_switch_timeout == 16'h0000) ? ST_IDLE : ST_SYNC_SWITCH;
         end
         ST_SYNC_SWITCH: begin
            if (blocked) state_next = ST_IDLE;
            else if (sync_switch_impulse_in) state_next = ST_PULSE;
            else if (timer_at && timer_ms_reg + 16'h0001 >= sync_switch_timeout)
               state_next = ST_IDLE;
         end
         ST_PULSE: begin
            if (blocked || pulse_done || early_done) state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end
   // Sequencer, timebase and per-state millisecond timer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ST_IDLE;
         presc_reg    <= 16'h0000;
         timer_ms_reg <= 16'h0000;
      end else begin
         state_reg    <= state_next;
         presc_reg    <= ms_tick ? 16'h0000 : presc_reg + 16'h0001;
         if (state_next != state_reg) timer_ms_reg <= 16'h0000;
         else if (ms_tick && timer_ms_reg != 16'hFFFF) timer_ms_reg <= timer_ms_reg + 16'h0001;
      end
   end
   // Configuration latch; model and forced check hold their reset values until loaded
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         model_reg     <= MODEL_RESET;
         forced_reg    <= FORCED_CHECK_RESET;
         dir_close_reg <= 1'b0;
      end else begin
         if (config_load && state_reg == ST_IDLE) begin // Not mid command: avoids model swap
            model_reg  <= (control_model_select > MODEL_SBO_ENH) ? MODEL_RESET
                          : control_model_select;
            forced_reg <= forced_check;
         end
         if (state_reg == ST_IDLE && remote_sel && !blocked) dir_close_reg <= remote_dir_close;
         else if (go_cmd) dir_close_reg <= req_close;
      end
   end

   // Command outputs follow the sequencer state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         open_cmd_reg  <= 1'b0;
         close_cmd_reg <= 1'b0;
         sw_start_reg  <= 1'b0;
         refused_reg   <= 1'b0;
         sel_reg       <= 1'b0;
      end else begin
         open_cmd_reg  <= (state_next == ST_PULSE) && !(go_cmd ? req_close : dir_close_reg);
         close_cmd_reg <= (state_next == ST_PULSE) && (go_cmd ? req_close : dir_close_reg);
         sw_start_reg  <= (state_next == ST_SYNC_SWITCH) && (sync_switch_timeout != 16'h0000);
         refused_reg   <= refuse;
         sel_reg       <= (state_next == ST_SELECTED);
      end
   end

   // Operating-time supervision in the enhanced models
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sup_active_reg <= 1'b0;
         sup_ms_reg     <= 16'h0000;
         invalid_reg    <= 1'b0;
      end else begin
         invalid_reg <= 1'b0;
         if (state_reg != ST_PULSE && state_next == ST_PULSE && enhanced) begin
            sup_active_reg <= 1'b1;
            sup_ms_reg     <= 16'h0000;
         end else if (sup_active_reg) begin
            if (pos_change || target_hit) sup_active_reg <= 1'b0;
            else if (ms_tick) begin
               if (sup_ms_reg + 16'h0001 >= oper_time_ms) begin
                  sup_active_reg <= 1'b0;
                  invalid_reg    <= 1'b1;
               end
               sup_ms_reg <= sup_ms_reg + 16'h0001;
            end
         end
      end
   end

   // Filtered position, intermediate supervision and operation indication
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         known_reg     <= 1'b0;
         opened_reg    <= 1'b0;
         closed_reg    <= 1'b0;
         interm_reg    <= 1'b0;
         interm_ms_reg <= 16'h0000;
         oper_reg      <= 1'b0;
         oper_ms_reg   <= 16'h0000;
         event_reg     <= 1'b0;
         count_reg     <= '0;
         unint_reg     <= 1'b0;
      end else begin
         event_reg <= pos_change;
         if (status_valid) begin
            known_reg     <= 1'b1;
            opened_reg    <= open_status_in;
            closed_reg    <= closed_status_in;
            interm_reg    <= 1'b0;
            interm_ms_reg <= 16'h0000;
         end else if (ms_tick && !interm_reg) begin
            if (interm_ms_reg + 16'h0001 >= interm_time_ms) interm_reg <= 1'b1;
            interm_ms_reg <= interm_ms_reg + 16'h0001;
         end
         if (pos_change) begin
            count_reg   <= count_reg + 1'b1;
            oper_reg    <= 1'b1;
            oper_ms_reg <= 16'h0000;
         end else if (oper_reg && ms_tick) begin
            if (oper_ms_reg + 16'h0001 >= OPER_PULSE_MS) oper_reg <= 1'b0;
            oper_ms_reg <= oper_ms_reg + 16'h0001;
         end
         // Set wins over the clear that a newly accepted command gives
         if (pos_change && !cmd_window && !external_command_seen) unint_reg <= 1'b1;
         else if (go_cmd) unint_reg <= 1'b0;
      end
   end
   // All outputs straight from flip-flops
   assign open_command_out         = open_cmd_reg;
   assign close_command_out        = close_cmd_reg;
   assign sync_switch_start        = sw_start_reg;
   assign operation_out            = oper_reg;
   assign operation_event_out      = event_reg;
   assign operation_count          = count_reg;
   assign unintended_operation_out = unint_reg;
   assign opened_out               = opened_reg;
   assign closed_out               = closed_reg;
   assign intermediate_out         = interm_reg;
   assign invalid_position_out     = invalid_reg;
   assign select_active_out        = sel_reg;
   assign cmd_refused_out          = refused_reg;
   // Checks kept beside the logic
   sequence s_change;
      pos_change && !cmd_window && !external_command_seen;
   endsequence
   sequence s_flagged;
      unintended_operation_out && operation_out;
   endsequence
   property p_block_stops;
      @(posedge ref_clk) disable iff (!rst_n)
      blocked |=> !open_command_out && !close_command_out && !sync_switch_start;
   endproperty
   a_block_stops: assert property (p_block_stops)
      else $error("command output active while blocked");
   property p_open_permit;
      @(posedge ref_clk) disable iff (!rst_n)
      go_open |-> (open_permit || !chk) ##1 open_command_out;
   endproperty
   a_open_permit: assert property (p_open_permit)
      else $error("open command issued without permit or not driven");
   // Only in a ready state, so a command already under way cannot trip it
   property p_local_enable;
      @(posedge ref_clk) disable iff (!rst_n)
      (cmd_ready && (local_open_req || local_close_req) && !local_enable && !remote_operate_req)
         |=> !$rose(open_command_out) && !$rose(close_command_out);
   endproperty
   a_local_enable: assert property (p_local_enable)
      else $error("local command taken while local disabled");
   property p_switch_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(sync_switch_start) |-> $past(sync_switch_timeout) != 16'h0000;
   endproperty
   a_switch_zero: assert property (p_switch_zero)
      else $error("synchro switch start with zero limit");
   property p_min_pulse;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == ST_PULSE && state_next == ST_IDLE && !blocked && !pulse_done)
         |-> timer_ms_reg >= MIN_PULSE_MS;
   endproperty
   a_min_pulse: assert property (p_min_pulse)
      else $error("command pulse ended before least length");
   property p_interm_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      status_valid |=> !intermediate_out && (closed_out == $past(closed_status_in));
   endproperty
   a_interm_clear: assert property (p_interm_clear)
      else $error("valid status not reflected");
   property p_count;
      @(posedge ref_clk) disable iff (!rst_n)
      pos_change |=> operation_event_out && operation_out &&
                     operation_count == $past(operation_count) + 1'b1;
   endproperty
   a_count: assert property (p_count)
      else $error("operation not counted or indicated");
   property p_unintended;
      @(posedge ref_clk) disable iff (!rst_n)
      s_change ##1 1'b1 |-> s_flagged;
   endproperty
   a_unintended: assert property (p_unintended)
      else $error("unintended operation not flagged");
   property p_sbo_needs_select;
      @(posedge ref_clk) disable iff (!rst_n)
      (remote_take && sbo_mode) |-> state_reg == ST_SELECTED;
   endproperty
   a_sbo_needs_select: assert property (p_sbo_needs_select)
      else $error("SBO operate taken without selection");
endmodule // breaker_command_control

/* src/breaker_ctrl_pkg.sv */
// Constants, encodings and setting defaults for the breaker command controller
package breaker_ctrl_pkg;

   // Timebase: one millisecond tick derived from the 50 MHz system clock
   localparam int CLK_PERIOD_NS        = 20;
   localparam int MS_NS                = 1000000;
   localparam int CYCLES_PER_MS_DEF    = MS_NS / CLK_PERIOD_NS;

   // Fixed times in milliseconds
   localparam logic [15:0] MIN_PULSE_MS  = 16'h0064; // 100 ms least command pulse
   localparam logic [15:0] OPER_PULSE_MS = 16'h0096; // 150 ms operation indication

   // Setting defaults in milliseconds, for the party that drives the settings
   localparam logic [15:0] OPER_TIME_DEF     = 16'h00C8; // 200
   localparam logic [15:0] PULSE_TIME_DEF    = 16'h012C; // 300
   localparam logic [15:0] INTERM_TIME_DEF   = 16'h0064; // 100
   localparam logic [15:0] SYNC_WAIT_DEF     = 16'h03E8; // 1000
   localparam logic [15:0] SYNC_SWITCH_DEF   = 16'h0000; // 0
   localparam logic [15:0] SELECT_TIME_DEF   = 16'h1388; // 5000

   // Control model encodings and reset values of the latched configuration
   localparam logic [1:0] MODEL_DIRECT_NORMAL = 2'h0;
   localparam logic [1:0] MODEL_DIRECT_ENH    = 2'h1;
   localparam logic [1:0] MODEL_SBO_ENH       = 2'h2;
   localparam logic [1:0] MODEL_RESET         = MODEL_DIRECT_NORMAL;
   localparam logic       FORCED_CHECK_RESET  = 1'b1;

   // Width of the operation counter
   localparam int         OP_COUNT_W          = 16;

   // Command sequencing states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SELECTED,
      ST_SYNC_WAIT,
      ST_SYNC_SWITCH,
      ST_PULSE
   } cmd_state_e;

endpackage

/* sim/breaker_model.sv */
// Behavioural breaker drive and auxiliary contacts facing the command controller
`timescale 1ns/1ps

module breaker_model #(
   parameter int MOVE_CYCLES = 50
) (
   input  wire logic ref_clk,
   input  wire logic open_cmd,
   input  wire logic close_cmd,
   input  wire logic trip_in,
   input  wire logic stuck,
   input  wire logic force_mid,
   output logic      open_status,
   output logic      closed_status
);
   logic pos_closed_reg = 1'b1;
   int   travel         = 0;
   // Protection trip joins the block's open command ahead of the drive
   wire  want_open      = open_cmd | trip_in;
   wire  start_move     = !stuck && travel == 0 &&
                          ((want_open && pos_closed_reg) || (close_cmd && !pos_closed_reg));

   // Mechanism travels for a while; a stuck drive never moves
   always @(posedge ref_clk) begin
      if (start_move) begin
         travel <= MOVE_CYCLES;
      end else if (travel == 1) begin
         pos_closed_reg <= ~pos_closed_reg;
         travel         <= 0;
      end else if (travel > 1) begin
         travel <= travel - 1;
      end
   end

   // Both contacts drop while travelling, as a real breaker shows in mid-stroke
   assign open_status   = !force_mid && travel == 0 && !pos_closed_reg;
   assign closed_status = !force_mid && travel == 0 && pos_closed_reg;
endmodule // breaker_model

/* sim/breaker_command_control_tb.sv */
// Self-checking bench for the breaker command controller
`timescale 1ns/1ps

module breaker_command_control_tb;
   import breaker_ctrl_pkg::*;
   localparam int CPM = 10;
   logic ref_clk = 0, rst_n = 0, config_load = 0, forced_check = 1, clr = 0;
   logic [1:0] control_model_select = MODEL_DIRECT_NORMAL;
   logic local_enable = 1, remote_enable = 1, local_open_req = 0, local_close_req = 0;
   logic remote_select_req = 0, remote_operate_req = 0, remote_dir_close = 0;
   logic remote_skip_check = 0, open_permit = 1, close_permit = 1, user_block_in = 0;
   logic process_block_in = 0, sync_ok_in = 1, sync_switch_impulse_in = 0;
   logic external_command_seen = 0, trip_in = 0, stuck = 0, force_mid = 0;
   logic [15:0] oper_time_ms = 16'h0014, sync_wait_timeout = 16'h000A;
   logic [15:0] sync_switch_timeout = 16'h0000;
   logic open_status_in, closed_status_in, open_command_out, close_command_out;
   logic sync_switch_start, operation_out, operation_event_out, unintended_operation_out;
   logic opened_out, closed_out, intermediate_out, invalid_position_out;
   logic select_active_out, cmd_refused_out;
   logic [OP_COUNT_W-1:0] operation_count;
   logic [15:0] h_open = 0, h_close = 0, h_oper = 0, h_sss = 0, n_ref = 0, n_inv = 0, n_evt = 0;
   int fails = 0, total_checks = 0, cyc = 0;

   breaker_command_control #(.CYCLES_PER_MS(CPM)) dut (
      .ref_clk, .rst_n, .config_load, .control_model_select, .forced_check,
      .oper_time_ms, .pulse_time_ms(16'h00C8), .interm_time_ms(16'h0014),
      .sync_wait_timeout, .sync_switch_timeout, .select_timeout(16'h03E8),
      .local_enable, .remote_enable, .local_open_req, .local_close_req, .remote_select_req,
      .remote_operate_req, .remote_dir_close, .remote_skip_check, .open_permit, .close_permit,
      .user_block_in, .process_block_in, .sync_ok_in, .sync_switch_impulse_in,
      .open_status_in, .closed_status_in, .external_command_seen, .open_command_out,
      .close_command_out, .sync_switch_start, .operation_out, .operation_event_out,
      .operation_count, .unintended_operation_out, .opened_out, .closed_out,
      .intermediate_out, .invalid_position_out, .select_active_out, .cmd_refused_out);

   breaker_model #(.MOVE_CYCLES(50)) cb (
      .ref_clk, .open_cmd(open_command_out), .close_cmd(close_command_out), .trip_in,
      .stuck, .force_mid, .open_status(open_status_in), .closed_status(closed_status_in));

   // 50 MHz clock
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   // Tally high cycles of outputs; counting avoids racing on short pulses
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (clr) begin
         {h_open, h_close, h_oper, h_sss, n_ref, n_inv, n_evt} <= '0;
      end else begin
         h_open  <= h_open + open_command_out;
         h_close <= h_close + close_command_out;
         h_oper  <= h_oper + operation_out;
         h_sss   <= h_sss + sync_switch_start;
         n_ref   <= n_ref + cmd_refused_out;
         n_inv   <= n_inv + invalid_position_out;
         n_evt   <= n_evt + operation_event_out;
      end
      if (cyc == 40000) begin
         fails++;
         results();
      end
   end

   task automatic step(input int ms);
      repeat (ms * CPM) @(posedge ref_clk);
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Millisecond limits carry one tick of prescaler phase, hence a window
   task automatic chk_rng(input string what, input logic [15:0] lo, input logic [15:0] hi,
                          input logic [15:0] got);
      total_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         fails++;
         $display("[ERR] %s expected %h..%h seen %h", what, lo, hi, got);
      end
   endtask

   task automatic clear;
      @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
   endtask

   task automatic loc(input logic cls);
      @(posedge ref_clk);
      local_open_req  <= !cls;
      local_close_req <= cls;
      @(posedge ref_clk);
      local_open_req  <= 1'b0;
      local_close_req <= 1'b0;
   endtask

   task automatic rem(input logic sel, input logic cls);
      @(posedge ref_clk);
      remote_select_req  <= sel;
      remote_operate_req <= !sel;
      remote_dir_close   <= cls;
      @(posedge ref_clk);
      remote_select_req  <= 1'b0;
      remote_operate_req <= 1'b0;
   endtask

   task automatic cfg(input logic [1:0] md);
      @(posedge ref_clk);
      control_model_select <= md;
      config_load          <= 1'b1;
      @(posedge ref_clk);
      config_load          <= 1'b0;
   endtask

   // A close that must not reach the breaker
   task automatic try_close(input logic remote, input logic exp_ref);
      clear();
      if (remote) rem(0, 1);
      else loc(1);
      step(15);
      chk("close pulse", 0, h_close);
      chk("sync start", 0, h_sss);
      chk("refused", exp_ref, n_ref);
   endtask

   task automatic results;
      if (fails == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      step(10);
      chk("closed_out", 1, closed_out);
      chk("opened_out", 0, opened_out);
      chk("count", 0, operation_count);
      clear();
      loc(0);
      step(200);
      chk_rng("open pulse", 990, 1012, h_open);
      chk("opened_out", 1, opened_out);
      chk("count", 1, operation_count);
      chk("event", 1, n_evt);
      chk_rng("oper pulse", 1488, 1512, h_oper);
      chk("unintended", 0, unintended_operation_out);
      close_permit <= 1'b0;
      try_close(0, 1);
      close_permit <= 1'b1;
      local_enable <= 1'b0;
      try_close(0, 0);
      local_enable <= 1'b1;
      user_block_in <= 1'b1;
      try_close(0, 1);
      user_block_in <= 1'b0;
      process_block_in <= 1'b1;
      try_close(0, 1);
      process_block_in <= 1'b0;
      close_permit <= 1'b0;
      remote_skip_check <= 1'b1;
      try_close(1, 1);
      close_permit <= 1'b1;
      sync_ok_in <= 1'b0;
      try_close(0, 0);
      sync_ok_in <= 1'b1;
      rem(0, 1);
      step(200);
      chk("closed_out", 1, closed_out);
      chk("count", 2, operation_count);
      // Stuck drive: normal model stays silent, enhanced reports bad position
      for (int m = 0; m < 2; m++) begin
         cfg(m[0] ? MODEL_DIRECT_ENH : MODEL_DIRECT_NORMAL);
         stuck <= 1'b1;
         clear();
         loc(0);
         step(250);
         chk_rng("full pulse", 1990, 2012, h_open);
         chk("invalid pos", m[15:0], n_inv);
      end
      stuck <= 1'b0;
      cfg(MODEL_SBO_ENH);
      clear();
      rem(1, 0);
      step(2);
      chk("selected", 1, select_active_out);
      step(990);
      chk("selected", 1, select_active_out);
      step(20);
      chk("selected", 0, select_active_out);
      chk("open pulse", 0, h_open);
      // Matching operate inside the select window closes; closed breaker ends it early
      clear();
      rem(1, 1);
      step(2);
      rem(0, 1);
      step(150);
      chk_rng("sbo close pulse", 16'h03DE, 16'h03F4, h_close);
      chk("invalid pos", 0, n_inv);
      rem(1, 1);
      step(2);
      rem(0, 0);
      step(1);
      chk("selected", 0, select_active_out);
      chk("open pulse", 0, h_open);
      chk("refused", 1, n_ref);
      force_mid <= 1'b1;
      step(15);
      chk("intermediate", 0, intermediate_out);
      step(10);
      chk("intermediate", 1, intermediate_out);
      force_mid <= 1'b0;
      step(1);
      chk("intermediate", 0, intermediate_out);
      clear();
      trip_in <= 1'b1;
      step(10);
      trip_in <= 1'b0;
      step(200);
      chk("unintended", 1, unintended_operation_out);
      chk("count", 3, operation_count);
      chk("event", 1, n_evt);
      // Synchro switch with a real limit: first runs out, second gets its impulse
      sync_ok_in          <= 1'b0;
      sync_switch_timeout <= 16'h000A;
      clear();
      loc(1);
      step(30);
      chk_rng("sync start", 16'h005A, 16'h0065, h_sss);
      chk("close pulse", 0, h_close);
      clear();
      loc(1);
      step(15);
      sync_switch_impulse_in <= 1'b1;
      step(1);
      sync_switch_impulse_in <= 1'b0;
      step(200);
      chk("closed_out", 1, closed_out);
      chk("count", 4, operation_count);
      chk("unintended", 0, unintended_operation_out);
      results();
   end
endmodule // breaker_command_control_tb
